// ---- verilog/sram_ctl.sv ----
// Purpose: Host-side controller driving an asynchronous 8K x 8 static RAM
// Assumes: Inputs synchronous to mclk; one request at a time
// Notes:   Strobe-controlled writes, gate held high outside reads
`timescale 1ns/1ns
// Notes on behaviour
// (R1) Both selects active makes the memory decode thirteen lines to one word.
// (R2) Either select inactive deselects the memory, floating data, standby power.
// (R3) Gate high forces memory data drivers off whatever else happens.
// (R4) Read: strobe high, selected; memory drives only with gate low.
// (R5) Read data appears an access delay after the last enabling event.
// (R6) Selected with gate low, data follows each address change.
// (R7) Stable address at selection gives data at later of select and gate delay.
// (R8) Select access does not depend on prior deselect length.
// (R9) Write spans from last select or strobe start to first reversal.
// (R10) During write the memory stores data lines and floats outputs.
// (R11) Gate low in strobe write lets outputs turn on briefly.
// (R12) Strobe already low at selection keeps memory outputs off.
// (R13) Strobe-ended write references data setup and hold to strobe rise.
// (R14) Select-ended write references data to select release; outputs float.
// (R15) Address changes only while a select or the strobe is inactive.
// (R16) Address stable from write start until after write end.
// (R17) Selects active at least the grade time before write end.
// (R18) Write data valid before write end by grade; held zero after.
// (R19) Address valid at least the grade time before write end.
// (R20) Fast writes allowed when continuously selected with gate high.
// (R21) Fast write data and address valid before strobe rises.
// (R22) Gate stays high except when reading, avoiding bus contention.
// (R23) Data valid within select access time by grade.
// (R24) Read data held at least five ns after address change.
// (R25) Data valid within gate access time by grade.
module sram_ctl
   import sram_ctl_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic      [DATA_W-1:0] rsp_rdata,
   output logic      [ADDR_W-1:0] word_select_lines,
   output logic                   select_low_active_b,
   output logic                   select_high_active,
   output logic                   write_strobe_b,
   output logic                   output_gate_b,
   input  wire logic [DATA_W-1:0] shared_data_lines_in,
   output logic      [DATA_W-1:0] shared_data_lines_out,
   output logic                   shared_data_lines_oe
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_RD_WAIT, ST_WR_PULSE, ST_HOLD
   } state_t;
   typedef struct packed {
      state_t              st;
      logic                wr;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic [DATA_W-1:0]   rdata;
      logic                rsp;
      logic                sel;
      logic                strobe;
      logic                gate;
      logic                drive;
   } ctl_t;
   ctl_t s_r;
   ctl_t s_nxt;
   logic             tmr_load;
   logic [CNT_W-1:0] tmr_val;
   logic             tmr_done;
   cycle_timer #(.W(CNT_W)) u_timer (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );
   always_comb begin
      s_nxt    = s_r;
      tmr_load = 1'b0;
      tmr_val  = CNT_ZERO;
      s_nxt.rsp = 1'b0;
      unique case (s_r.st)
         ST_IDLE: begin
            // Address only moves while deselected and strobe high
            if (req_valid) begin // R15
               s_nxt.addr  = req_addr; // R15
               s_nxt.wr    = req_write;
               s_nxt.wdata = req_wdata;
               s_nxt.st    = ST_SETUP;
               tmr_load    = 1'b1;
               tmr_val     = CNT_W'(SETUP_CYC - 1);
            end
         end
         ST_SETUP: begin
            // Address has stood a full cycle before selection
            if (tmr_done) begin
               s_nxt.sel = 1'b1; // R1 R16
               if (s_r.wr) begin
                  // Gate stays high so memory never drives during the write
                  // Every write reselects; back-to-back fast writes are never issued
                  s_nxt.strobe = 1'b1; // R9 R12 R20
                  s_nxt.drive  = 1'b1; // R18 R22
                  s_nxt.st     = ST_WR_PULSE;
                  tmr_load     = 1'b1;
                  tmr_val      = CNT_W'(STROBE_CYC - 1); // R17 R19 R21
               end else begin
                  s_nxt.gate = 1'b1; // R4 R22
                  s_nxt.st   = ST_RD_WAIT;
                  tmr_load   = 1'b1;
                  tmr_val    = CNT_W'(ACCESS_CYC - 1); // R5 R7 R23 R25
               end
            end
         end
         ST_RD_WAIT: begin
            if (tmr_done) begin
               s_nxt.rdata = shared_data_lines_in; // R5 R6 R8
               s_nxt.rsp   = 1'b1;
               s_nxt.gate  = 1'b0; // R3 R22
               s_nxt.sel   = 1'b0; // R2
               s_nxt.st    = ST_HOLD;
               tmr_load    = 1'b1;
               tmr_val     = CNT_W'(HOLD_CYC - 1);
            end
         end
         ST_WR_PULSE: begin
            if (tmr_done) begin
               // Strobe rises first; selects and data stay one more cycle
               s_nxt.strobe = 1'b0; // R9 R13
               s_nxt.st     = ST_HOLD;
               tmr_load     = 1'b1;
               tmr_val      = CNT_W'(HOLD_CYC - 1);
            end
         end
         ST_HOLD: begin
            if (tmr_done) begin
               s_nxt.sel   = 1'b0; // R16
               s_nxt.drive = 1'b0; // R18
               s_nxt.st    = ST_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign req_ready             = (s_r.st == ST_IDLE);
   assign rsp_valid             = s_r.rsp;
   assign rsp_rdata             = s_r.rdata;
   assign word_select_lines     = s_r.addr;
   assign select_low_active_b   = ~s_r.sel;
   assign select_high_active    = s_r.sel;
   assign write_strobe_b        = ~s_r.strobe;
   assign output_gate_b         = ~s_r.gate; // R22
   assign shared_data_lines_out = s_r.wdata;
   assign shared_data_lines_oe  = s_r.drive; // R10 R22
endmodule : sram_ctl

// ---- verilog/sram_ctl_pkg.sv ----
// Purpose: Constants for the asynchronous 8K x 8 static RAM controller
// Assumes: 10 MHz controller clock, 100 ns period
// Notes:   Times in ns as printed for the slowest speed grade; cycle counts derived
package sram_ctl_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int ADDR_W        = 13;
   localparam int DATA_W        = 8;
   // Slowest grade figures; at 100 ns per cycle every one fits in one cycle
   localparam int ACCESS_NS        = 70;
   localparam int GATE_ACCESS_NS   = 25;
   localparam int SEL_TO_END_NS    = 50;
   localparam int ADDR_TO_END_NS   = 50;
   localparam int DATA_TO_END_NS   = 25;
   localparam int STROBE_FLOAT_NS  = 25;
   localparam int ADDR_SETUP_NS    = 0;
   localparam int HOLD_NS          = 0;
   // Least times round up, never below one cycle
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc
   localparam int ACCESS_CYC     = ns_to_cyc(ACCESS_NS);
   localparam int STROBE_CYC     = ns_to_cyc(SEL_TO_END_NS);
   localparam int FLOAT_CYC      = ns_to_cyc(STROBE_FLOAT_NS);
   localparam int SETUP_CYC      = ns_to_cyc(ADDR_SETUP_NS);
   localparam int HOLD_CYC       = ns_to_cyc(HOLD_NS);
   localparam int CNT_W          = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
endpackage : sram_ctl_pkg

// ---- verilog/cycle_timer.sv ----
// Purpose: Down counter that marks the end of a timed phase
// Assumes: Load and count share one clock; load wins
// Notes:   done is high while the count stands at zero
`timescale 1ns/1ns
module cycle_timer
   import sram_ctl_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic              done
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } tmr_t;
   tmr_t s_r;
   tmr_t s_nxt;
   always_comb begin
      s_nxt = s_r;
      if (load) begin
         s_nxt.cnt = load_val;
      end else if (s_r.cnt != '0) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign done = (s_r.cnt == '0);
endmodule : cycle_timer

// ---- tb/sram_model.sv ----
// Purpose: 8K x 8 static RAM model. Assumes: zero access delay.
// Notes: a released bus shows the inverse of the last value driven, never a held copy
`timescale 1ns/1ns
module sram_model
   import sram_ctl_pkg::*;
(
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              lo_b, hi, wr_b, gate_b,
   input  wire logic [DATA_W-1:0] din,
   output logic      [DATA_W-1:0] dout
);
   logic [DATA_W-1:0] mem [0:8191];
   logic [DATA_W-1:0] last = 8'h00;
   wire               drv = !lo_b && hi && wr_b && !gate_b;
   assign dout = drv ? mem[addr] : ~last;
   always @(*) if (drv) last = mem[addr];
   always @(posedge wr_b) if (!lo_b && hi) mem[addr] <= din;
endmodule : sram_model

// ---- tb/sram_ctl_chk.sv ----
// Purpose: Port assertions for the RAM controller. Assumes: one clock domain.
// Notes: ports grouped to keep the file short
`timescale 1ns/1ns
module sram_ctl_chk
   import sram_ctl_pkg::*;
(
   input wire logic              mclk, rst_b, req_valid, req_write, req_ready, rsp_valid,
   input wire logic [DATA_W-1:0] rsp_rdata, shared_data_lines_in, shared_data_lines_out,
   input wire logic [ADDR_W-1:0] word_select_lines,
   input wire logic              select_low_active_b, select_high_active, write_strobe_b,
   input wire logic              output_gate_b, shared_data_lines_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   wire take = req_valid && req_ready;
   a_sel_pair: assert property (select_low_active_b == !select_high_active)
      else $error("selects disagree");
   a_gate_no_write: assert property (!output_gate_b |-> write_strobe_b && !shared_data_lines_oe)
      else $error("gate low while writing");
   a_addr_held: assert property (!select_low_active_b |-> $stable(word_select_lines))
      else $error("address moved while selected");
   a_strobe_sel: assert property (!write_strobe_b |-> !select_low_active_b && shared_data_lines_oe)
      else $error("strobe outside selection");
   a_write_shape: assert property ($fell(write_strobe_b) |=> write_strobe_b && !select_low_active_b
      && $stable(shared_data_lines_out) ##1 select_low_active_b)
      else $error("write end order wrong");
   a_sel_setup: assert property ($rose(write_strobe_b) |-> !$past(select_low_active_b))
      else $error("select too late before write end");
   a_read_lat: assert property (take && !req_write |=> !rsp_valid [*2] ##1 rsp_valid)
      else $error("read answer late");
   a_ready_gap: assert property (take |=> !req_ready [*3] ##1 req_ready)
      else $error("ready gap wrong");
   a_rdata_bus: assert property (rsp_valid |-> rsp_rdata == $past(shared_data_lines_in))
      else $error("read data not from bus");
   c_read: cover property (take && !req_write);
   c_write: cover property (take && req_write);
   c_rsp: cover property (rsp_valid);
endmodule : sram_ctl_chk
bind sram_ctl sram_ctl_chk chk_u (.mclk, .rst_b, .req_valid, .req_write, .req_ready, .rsp_valid,
   .rsp_rdata, .shared_data_lines_in, .shared_data_lines_out, .word_select_lines,
   .select_low_active_b, .select_high_active, .write_strobe_b, .output_gate_b,
   .shared_data_lines_oe);

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the RAM controller. Assumes: inputs move 1 ns after edge.
// Notes: read answer timing is the fixed figure of the hand-over
`timescale 1ns/1ns
module tb_top
   import sram_ctl_pkg::*;
;
   logic              mclk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic [ADDR_W-1:0] req_addr = 13'h0000, wa;
   logic [DATA_W-1:0] req_wdata = 8'h00, bus, c_out, m_out, rsp_rdata;
   logic              req_ready, rsp_valid, lo_b, hi, wr_b, gate_b, c_oe;
   int                n_errors = 0, tests_run = 0, cyc = 0;
   assign bus = c_oe ? c_out : m_out;
   initial forever #50 mclk = ~mclk;
   sram_ctl dut_u (.mclk, .rst_b, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
      .rsp_valid, .rsp_rdata, .word_select_lines(wa), .select_low_active_b(lo_b),
      .select_high_active(hi), .write_strobe_b(wr_b), .output_gate_b(gate_b),
      .shared_data_lines_in(bus), .shared_data_lines_out(c_out), .shared_data_lines_oe(c_oe));
   sram_model mem_u (.addr(wa), .lo_b, .hi, .wr_b, .gate_b, .din(bus), .dout(m_out));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      while (req_ready !== 1'b1) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
   endtask : xfer
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      xfer(1'b0, a, 8'h00);
      repeat (2) @(posedge mclk);
      #1;
      chk("rsp", {7'h00, 1'b1, exp}, {7'h00, rsp_valid, rsp_rdata});
      @(posedge mclk);
      #1;
      chk("rsp pulse", 16'h0000, {15'h0000, rsp_valid});
   endtask : rd
   task automatic t_idle;
      chk("idle pins", 16'h002D, {10'h000, lo_b, hi, wr_b, gate_b, c_oe, req_ready});
      $display("t_idle done");
   endtask : t_idle
   task automatic t_write_read;
      xfer(1'b1, 13'h0000, 8'h5A);
      xfer(1'b1, 13'h1FFF, 8'hA5);
      xfer(1'b1, 13'h0AAA, 8'h3C);
      rd(13'h1FFF, 8'hA5);
      rd(13'h0000, 8'h5A);
      rd(13'h0AAA, 8'h3C);
      $display("t_write_read done");
   endtask : t_write_read
   task automatic t_refused;
      xfer(1'b1, 13'h0001, 8'h11);
      @(posedge mclk);
      #1;
      req_valid = 1'b1;
      req_wdata = 8'hEE;
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      rd(13'h0001, 8'h11);
      $display("t_refused done");
   endtask : t_refused
   task automatic t_reset_mid;
      xfer(1'b1, 13'h0003, 8'h77);
      @(posedge mclk);
      #1;
      rst_b = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      chk("reset pins", 16'h002D, {10'h000, lo_b, hi, wr_b, gate_b, c_oe, req_ready});
      $display("t_reset_mid done");
   endtask : t_reset_mid
   task automatic give_verdict;
      $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 1000) begin
         n_errors++;
         give_verdict;
      end
   end
   initial begin
      repeat (5) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      t_idle;
      t_write_read;
      t_refused;
      t_reset_mid;
      rd(13'h0AAA, 8'h3C);
      t_idle;
      give_verdict;
   end
endmodule : tb_top
